// ### verilog/led_dim_defs.svh
`ifndef LED_DIM_DEFS_SVH
`define LED_DIM_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define CTRL_RESET 6'h20
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 40
`define PWM_SHORT_US 10
`define PWM_SHORT_CYC (`PWM_SHORT_US * `CLK_MHZ)
`define TIMEOUT_NS 6500
`define TIMEOUT_CYC ((`TIMEOUT_NS * `CLK_MHZ) / 1000)
`define STOP_PULSES 3'd4
// ----------------------------------------
// setpoint scale, 1023 is full (1 V)
// ----------------------------------------
`define SP_FULL 10'h3ff
`define SP_93 10'h3b8
`define SP_15 10'h099
`define CLAMP_1 10'h00a
`define CLAMP_5 10'h033
`define CLAMP_8 10'h052
`define ANALOG_DIM_INPUT_MIN 10'h0e0
`define ANALOG_DIM_INPUT_EN 10'h100
`define ANALOG_DIM_INPUT_FS 10'h300
`endif

// ### verilog/led_dim_pkg.sv
package led_dim_pkg;
	// switching sequence, gray along idle-on-off-fault
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ON = 2'b01,
		ST_OFF = 2'b11,
		ST_FAULT = 2'b10
	} sw_state_type;
	// software control word
	typedef struct packed {
		logic enable;
		logic cv_option;
		logic hl_extra;
		logic curve_sel;
		logic [1:0] clamp_sel;
	} ctrl_type;
	// comparator bundle from the power stage
	typedef struct packed {
		logic cs_limit;
		logic cs_stop;
		logic valley;
		logic zcd_high;
		logic line_high;
		logic pwm_open;
		logic demag;
		logic pwm;
	} sense_type;
endpackage : led_dim_pkg

// ### verilog/led_dimming_valley_control.sv
`timescale 1ns/1ps
`include "led_dim_defs.svh"
module led_dimming_valley_control #(
	parameter int LOW_OFF_CYC = 1000000,
	parameter int SHORT_HOLD_CYC = 800000,
	parameter int LOSS_CYC = 1000000,
	parameter int RECOVER_CYC = 160000000,
	parameter int BLANK_SHORT_CYC = 8,
	parameter int BLANK_MAIN_CYC = 16,
	parameter int MAX_ON_CYC = 1000,
	parameter int FF_OFF_CYC = 400
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire led_dim_pkg::sense_type sense_pins,
	input wire logic [9:0] analog_dim_input,
	output logic gate_drive_output,
	output logic [9:0] current_setpoint,
	output logic reduced_voltage_regulation_flag,
	output logic sense_offset_current,
	output logic fault_out
);
	import led_dim_pkg::*;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// scaled product of two unit fractions
	function automatic logic [9:0] frac_mul(input logic [9:0] a,
		input logic [9:0] b);
		logic [19:0] p;
		p = a * b;
		return p[19:10];
	endfunction : frac_mul

	// square-law lightness curve or straight line
	function automatic logic [9:0] shape(input logic [9:0] x,
		input logic sel);
		return sel ? frac_mul(x, x) : x;
	endfunction : shape

	// setpoint below which valley v is left (falling)
	function automatic logic [9:0] down_th(input logic [2:0] v);
		case (v)
			3'd1: return 10'h333;
			3'd2: return 10'h299;
			3'd3: return 10'h200;
			default: return 10'h100;
		endcase
	endfunction : down_th

	// setpoint at or above which valley v+1 returns to v
	function automatic logic [9:0] up_th(input logic [2:0] v);
		case (v)
			3'd1: return 10'h399;
			3'd2: return 10'h300;
			3'd3: return 10'h266;
			default: return 10'h166;
		endcase
	endfunction : up_th

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	sense_type s1_r; // first stage, read only by s2_r
	sense_type s2_r; // safe copy
	logic pwm_d_r; // for edge detection
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			pwm_d_r <= 1'b0;
		end else begin
			s1_r <= sense_pins;
			s2_r <= s1_r;
			pwm_d_r <= s2_r.pwm;
		end
	end
	logic pwm_rise;
	logic pwm_fall;
	assign pwm_rise = s2_r.pwm & ~pwm_d_r;
	assign pwm_fall = ~s2_r.pwm & pwm_d_r;

	// ----------------------------------------
	// avalon slave
	// ----------------------------------------
	ctrl_type ctrl_r; // control word
	logic ack_r; // second cycle of an access
	logic [31:0] status_w;
	// one wait cycle, then the access completes
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			ctrl_r <= `CTRL_RESET;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
			// write lands only at the accepting edge, waitrequest low
			if (avs_write && ack_r && avs_address == `REG_CTRL) begin
				ctrl_r <= avs_writedata[5:0];
			end
			// unmapped reads return zero
			if (avs_read && !ack_r) begin
				case (avs_address)
					`REG_CTRL: avs_readdata <= {26'h0, ctrl_r};
					`REG_STATUS: avs_readdata <= status_w;
					default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// pwm duty measurement
	// ----------------------------------------
	logic [19:0] hi_cnt_r; // high time, fast clock
	logic [19:0] per_cnt_r; // period since last rise
	logic [19:0] low_cnt_r; // continuous low time
	logic [19:0] short_cnt_r; // time with short on-times
	logic short_r; // last on-time under 10 us
	logic seen_r; // a rising edge has been measured
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			hi_cnt_r <= 20'h0_0000;
			per_cnt_r <= 20'h0_0000;
			low_cnt_r <= 20'h0_0000;
			short_cnt_r <= 20'h0_0000;
			short_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			// both counters saturate rather than wrap
			if (pwm_rise) begin
				per_cnt_r <= 20'h0_0001;
				hi_cnt_r <= 20'h0_0000;
				seen_r <= 1'b1;
			end else begin
				if (per_cnt_r != 20'hf_ffff)
					per_cnt_r <= per_cnt_r + 20'h0_0001;
				if (s2_r.pwm && hi_cnt_r != 20'hf_ffff)
					hi_cnt_r <= hi_cnt_r + 20'h0_0001;
			end
			if (s2_r.pwm)
				low_cnt_r <= 20'h0_0000;
			else if (low_cnt_r != 20'hf_ffff)
				low_cnt_r <= low_cnt_r + 20'h0_0001;
			if (pwm_fall)
				short_r <= hi_cnt_r < 20'(`PWM_SHORT_CYC);
			if (!short_r && s2_r.pwm)
				short_cnt_r <= 20'h0_0000;
			else if (short_cnt_r != 20'hf_ffff)
				short_cnt_r <= short_cnt_r + 20'h0_0001;
			// waveform gone: forget the old duty
			if (per_cnt_r >= 20'(LOSS_CYC))
				seen_r <= 1'b0;
		end
	end
	logic pwm_low_off;
	logic pwm_short;
	assign pwm_low_off = low_cnt_r >= 20'(LOW_OFF_CYC);
	assign pwm_short = short_cnt_r >= 20'(SHORT_HOLD_CYC);

	// ----------------------------------------
	// duty divider, restoring, 10 fraction bits
	// ----------------------------------------
	logic [20:0] rem_r;
	logic [19:0] div_r; // latched period
	logic [10:0] quo_r;
	logic [3:0] step_r; // 0 means idle
	logic done_r; // one-cycle quotient strobe
	logic [20:0] rem_sh;
	assign rem_sh = {rem_r[19:0], 1'b0};
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rem_r <= '0;
			div_r <= '0;
			quo_r <= '0;
			step_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			// first rise after reset or loss has no whole period behind it
			if (pwm_rise && seen_r && per_cnt_r != 20'h0_0000) begin
				rem_r <= {1'b0, hi_cnt_r};
				div_r <= per_cnt_r;
				quo_r <= {10'h000, hi_cnt_r >= per_cnt_r};
				step_r <= 4'hA;
			end else if (step_r != 4'h0) begin
				if (rem_sh >= {1'b0, div_r}) begin
					rem_r <= rem_sh - {1'b0, div_r};
					quo_r <= {quo_r[9:0], 1'b1};
				end else begin
					rem_r <= rem_sh;
					quo_r <= {quo_r[9:0], 1'b0};
				end
				step_r <= step_r - 4'h1;
				done_r <= step_r == 4'h1;
			end
		end
	end

	// ----------------------------------------
	// ripple filter, first order, gain 1/8
	// ----------------------------------------
	logic [12:0] filt_r; // eight times the duty
	logic [9:0] q_sat;
	// full duty or over 93% counts as full scale
	assign q_sat = (quo_r[10] || quo_r[9:0] > `SP_93) ? `SP_FULL
		: quo_r[9:0];
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			filt_r <= 13'h1ff8;
		else if (done_r)
			filt_r <= filt_r - {3'b000, filt_r[12:3]}
				+ {3'b000, q_sat};
	end

	// ----------------------------------------
	// setpoint composition
	// ----------------------------------------
	logic pwm_full; // pwm contributes 100%
	logic [9:0] pwm_val;
	logic [9:0] ana_lin;
	logic [9:0] ana_val;
	logic [9:0] clamp_val;
	logic [9:0] prod;
	logic [9:0] sp_nxt;
	logic ana_below_en;
	assign ana_below_en = analog_dim_input < `ANALOG_DIM_INPUT_EN;
	assign pwm_full = s2_r.pwm_open | ~seen_r;
	assign pwm_val = pwm_full ? `SP_FULL
		: shape(filt_r[12:3], ctrl_r.curve_sel);
	// span of 512 codes doubled to full scale
	always_comb begin
		if (analog_dim_input >= `ANALOG_DIM_INPUT_FS)
			ana_lin = `SP_FULL;
		else if (ana_below_en)
			ana_lin = 10'h000;
		else
			ana_lin = 10'((analog_dim_input - `ANALOG_DIM_INPUT_EN) << 1);
	end
	assign ana_val = shape(ana_lin, ctrl_r.curve_sel);
	always_comb begin
		case (ctrl_r.clamp_sel)
			2'd1: clamp_val = `CLAMP_1;
			2'd2: clamp_val = `CLAMP_5;
			2'd3: clamp_val = `CLAMP_8;
			default: clamp_val = 10'h000;
		endcase
	end
	assign prod = frac_mul(ana_val, pwm_val) | {10{ana_val == `SP_FULL
		&& pwm_val == `SP_FULL}};
	always_comb begin
		if (analog_dim_input < `ANALOG_DIM_INPUT_MIN)
			sp_nxt = clamp_val;
		else if (prod < clamp_val)
			sp_nxt = clamp_val;
		else
			sp_nxt = prod;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			current_setpoint <= `SP_FULL;
		else
			current_setpoint <= sp_nxt;
	end

	// ----------------------------------------
	// reduced regulation flag and offset
	// ----------------------------------------
	sw_state_type st_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reduced_voltage_regulation_flag <= 1'b0;
			sense_offset_current <= 1'b0;
		end else begin
			// clears as soon as both conditions are gone
			reduced_voltage_regulation_flag <= ana_below_en
				| pwm_short;
			// offset only while demagnetising, keeps valleys visible
			sense_offset_current <= reduced_voltage_regulation_flag
				& s2_r.demag & (st_r == ST_OFF);
		end
	end

	// ----------------------------------------
	// valley selection with hysteresis
	// ----------------------------------------
	logic [2:0] vbase_r; // 1..5 on the low line scale
	logic first_r; // force first valley after enable
	logic run_en;
	logic run_d_r;
	logic dimming;
	logic free_run;
	logic [2:0] vsel;
	assign dimming = current_setpoint != `SP_FULL;
	assign run_en = ctrl_r.enable & ~pwm_low_off & ~fault_out
		& ~(ana_below_en & ~ctrl_r.cv_option);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			vbase_r <= 3'd1;
			first_r <= 1'b0;
			run_d_r <= 1'b0;
		end else begin
			run_d_r <= run_en;
			if (vbase_r < 3'd5 && current_setpoint < down_th(vbase_r))
				vbase_r <= vbase_r + 3'd1;
			else if (vbase_r > 3'd1
				&& current_setpoint >= up_th(vbase_r - 3'd1))
				vbase_r <= vbase_r - 3'd1;
			if (run_en && !run_d_r && dimming)
				first_r <= 1'b1;
			else if (st_r == ST_OFF && s2_r.zcd_high)
				first_r <= 1'b0;
		end
	end
	// high line adds one valley, option adds another
	assign vsel = first_r ? 3'd1 : vbase_r + {2'b00, s2_r.line_high}
		+ {2'b00, s2_r.line_high & ctrl_r.hl_extra};
	assign free_run = ~first_r & (current_setpoint < `SP_15);

	// ----------------------------------------
	// switching sequence
	// ----------------------------------------
	logic [27:0] tmr_r; // on, off or recovery timer
	logic [2:0] vcnt_r; // valleys seen in this off time
	logic [2:0] stop_cnt_r; // consecutive 140% pulses
	logic stop_hit_r; // 140% seen in this pulse
	logic valley_d_r;
	logic valley_ev;
	logic [27:0] nxt_tmr;
	assign nxt_tmr = tmr_r + 28'h000_0001;
	// a missing valley is stood in for by the time-out
	assign valley_ev = (s2_r.valley & ~valley_d_r)
		| (tmr_r == 28'(`TIMEOUT_CYC));
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			tmr_r <= '0;
			vcnt_r <= 3'd0;
			stop_cnt_r <= 3'd0;
			stop_hit_r <= 1'b0;
			valley_d_r <= 1'b0;
			gate_drive_output <= 1'b0;
			fault_out <= 1'b0;
		end else begin
			valley_d_r <= s2_r.valley;
			unique case (st_r)
				ST_IDLE: begin
					if (run_en) begin
						st_r <= ST_ON;
						tmr_r <= '0;
						stop_hit_r <= 1'b0;
						gate_drive_output <= 1'b1;
					end
				end
				ST_ON: begin
					tmr_r <= nxt_tmr;
					if (tmr_r >= 28'(BLANK_SHORT_CYC) && s2_r.cs_stop)
						stop_hit_r <= 1'b1;
					// limit ends the pulse for the rest of the cycle
					if ((tmr_r >= 28'(BLANK_MAIN_CYC) && s2_r.cs_limit)
						|| tmr_r >= 28'(MAX_ON_CYC) || !run_en) begin
						gate_drive_output <= 1'b0;
						tmr_r <= '0;
						vcnt_r <= 3'd0;
						if (stop_hit_r && stop_cnt_r == `STOP_PULSES - 3'd1)
						begin
							st_r <= ST_FAULT;
							fault_out <= 1'b1;
							stop_cnt_r <= 3'd0;
						end else begin
							st_r <= run_en ? ST_OFF : ST_IDLE;
							stop_cnt_r <= stop_hit_r ? stop_cnt_r + 3'd1
								: 3'd0;
						end
					end
				end
				ST_OFF: begin
					// free run needs an unbroken off timer, valleys ignored
					tmr_r <= (valley_ev && !free_run) ? '0 : nxt_tmr;
					if (valley_ev)
						vcnt_r <= vcnt_r + 3'd1;
					if (!run_en) begin
						st_r <= ST_IDLE;
					end else if (free_run ? tmr_r >= 28'(FF_OFF_CYC)
						: (valley_ev && vcnt_r + 3'd1 >= vsel)) begin
						st_r <= ST_ON;
						tmr_r <= '0;
						stop_hit_r <= 1'b0;
						gate_drive_output <= 1'b1;
					end
				end
				ST_FAULT: begin
					// auto-recovery after the pause
					tmr_r <= nxt_tmr;
					if (tmr_r >= 28'(RECOVER_CYC)) begin
						st_r <= ST_IDLE;
						fault_out <= 1'b0;
						tmr_r <= '0;
					end
				end
			endcase
		end
	end

	// status word: state, valley, flags, setpoint
	assign status_w = {12'h000, st_r, vsel, first_r, free_run,
		reduced_voltage_regulation_flag, pwm_low_off, fault_out,
		current_setpoint};
endmodule : led_dimming_valley_control

// ### testbench/led_dim_checker.sv
`timescale 1ns/1ps
// --------
// port level checks
// --------
module led_dim_checker #(
	parameter int LOW_OFF_CYC = 1000000,
	parameter int BLANK_MAIN_CYC = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire led_dim_pkg::sense_type sense_pins,
	input wire logic [9:0] analog_dim_input,
	input wire logic gate_drive_output,
	input wire logic [9:0] current_setpoint,
	input wire logic reduced_voltage_regulation_flag,
	input wire logic sense_offset_current,
	input wire logic fault_out
);
	import led_dim_pkg::*;
	logic cv_r; // option bits seen on the bus
	logic curve_r;
	int lim_cnt; // gate high while limit seen
	int low_cnt; // pwm pin held low
	int full_cnt; // open pin and full analog
	// shadow of the control word, taken at the accepting edge
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cv_r <= 1'b0;
			curve_r <= 1'b0;
		end else if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
			cv_r <= avs_writedata[4];
			curve_r <= avs_writedata[2];
		end
	end
	// counters, cleared whenever their cause lapses
	always_ff @(posedge sys_clk) begin
		lim_cnt <= (rst_n && gate_drive_output && sense_pins.cs_limit) ?
			lim_cnt + 1 : 0;
	end
	always_ff @(posedge sys_clk) begin
		low_cnt <= (rst_n && !sense_pins.pwm && !sense_pins.pwm_open) ?
			low_cnt + 1 : 0;
	end
	always_ff @(posedge sys_clk) begin
		full_cnt <= (rst_n && sense_pins.pwm_open && !curve_r &&
			analog_dim_input >= 10'h300) ? full_cnt + 1 : 0;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_wait_first;
		$rose(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first)
		else $error("bus answered without wait cycle");
	property p_wait_second;
		$rose(avs_read || avs_write) |=> !avs_waitrequest;
	endproperty
	a_wait_second: assert property (p_wait_second)
		else $error("bus wait longer than one cycle");
	// sync plus blanking bounds how long the limit may be ignored
	property p_ilim;
		lim_cnt <= BLANK_MAIN_CYC + 6;
	endproperty
	a_ilim: assert property (p_ilim)
		else $error("gate kept on past peak limit");
	property p_fault_gate;
		fault_out && $past(fault_out) |-> !gate_drive_output;
	endproperty
	a_fault_gate: assert property (p_fault_gate)
		else $error("gate active during fault pause");
	property p_offset;
		sense_offset_current |-> reduced_voltage_regulation_flag ||
			$past(reduced_voltage_regulation_flag);
	endproperty
	a_offset: assert property (p_offset)
		else $error("offset current without flag");
	property p_flag_set;
		(analog_dim_input < 10'h100) [*4] |->
			##[0:4] reduced_voltage_regulation_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag missing with low analog level");
	property p_no_cv;
		(analog_dim_input < 10'h100 && !cv_r) [*8] ##0 !gate_drive_output
			|=> !gate_drive_output;
	endproperty
	a_no_cv: assert property (p_no_cv)
		else $error("pulse while analog below enable");
	property p_low_off;
		low_cnt > LOW_OFF_CYC + 64 |-> !gate_drive_output;
	endproperty
	a_low_off: assert property (p_low_off)
		else $error("switching with pwm input held low");
	property p_full;
		full_cnt > 1500 |-> current_setpoint == 10'h3ff;
	endproperty
	a_full: assert property (p_full)
		else $error("open pwm input not at full setpoint");
endmodule : led_dim_checker
bind led_dimming_valley_control led_dim_checker #(
	.LOW_OFF_CYC(LOW_OFF_CYC),
	.BLANK_MAIN_CYC(BLANK_MAIN_CYC)
) led_dim_checker_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .sense_pins(sense_pins),
	.analog_dim_input(analog_dim_input),
	.gate_drive_output(gate_drive_output),
	.current_setpoint(current_setpoint),
	.reduced_voltage_regulation_flag(reduced_voltage_regulation_flag),
	.sense_offset_current(sense_offset_current), .fault_out(fault_out)
);

// ### testbench/power_stage_model.sv
`timescale 1ns/1ps
// --------
// flyback sense comparators and opto input
// --------
module power_stage_model (
	input wire logic sys_clk,
	input wire logic gate,
	input wire logic [15:0] pwm_hi,
	input wire logic [15:0] pwm_per,
	input wire logic open,
	input wire logic line,
	input wire logic stop,
	output led_dim_pkg::sense_type pins
);
	import led_dim_pkg::*;
	int on_c; // cycles of current pulse
	int off_c; // cycles since gate fell
	int p_c; // opto period phase
	initial pins = '0;
	// ramp, ring and opto timing
	always @(posedge sys_clk) begin
		on_c <= gate ? on_c + 1 : 0;
		off_c <= gate ? 0 : off_c + 1;
		p_c <= (p_c + 1 >= pwm_per) ? 0 : p_c + 1;
	end
	// limit trips after main blanking so the gate has to act on it
	always @(posedge sys_clk) begin
		pins.cs_limit <= gate && on_c >= 30;
		pins.cs_stop <= gate && stop && on_c >= 10;
		pins.valley <= !gate && off_c >= 20 && off_c[2:0] == 3'h0;
		pins.zcd_high <= !gate && off_c < 20;
		pins.line_high <= line;
		pins.pwm_open <= open;
		pins.demag <= !gate && off_c < 20;
		pins.pwm <= open || p_c < pwm_hi;
	end
endmodule : power_stage_model

// ### testbench/led_dimming_valley_control_tb_top.sv
`timescale 1ns/1ps
module led_dimming_valley_control_tb_top;
	import led_dim_pkg::*;
	logic sys_clk = 0;
	logic rst_n = 0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, gate, flag, offs, fault_out;
	logic [9:0] analog = 10'h300;
	logic [9:0] sp;
	logic [15:0] hi = 16'h0000;
	logic open = 1;
	logic line = 0;
	logic stop = 0;
	sense_type pins;
	int n_errors = 0;
	int n_checks = 0;
	always #12.5 sys_clk = ~sys_clk;
	power_stage_model power_stage_model_inst (.sys_clk(sys_clk),
		.gate(gate), .pwm_hi(hi), .pwm_per(16'h00fa), .open(open),
		.line(line), .stop(stop), .pins(pins));
	// long counts shortened, pwm period of 250 fits inside all but the 100 cycle recovery pause
	// short period lets the ripple filter settle within each step
	led_dimming_valley_control #(.LOW_OFF_CYC(3000), .SHORT_HOLD_CYC(2000),
		.LOSS_CYC(3000), .RECOVER_CYC(100)) led_dimming_valley_control_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sense_pins(pins),
		.analog_dim_input(analog), .gate_drive_output(gate),
		.current_setpoint(sp), .reduced_voltage_regulation_flag(flag),
		.sense_offset_current(offs), .fault_out(fault_out));
	// --------
	// helpers
	// --------
	task stop_test;
		if (n_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	// tolerance covers filter rounding
	task check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
		n_checks++;
		if ($isunknown(seen) || seen > exp + tol || seen + tol < exp) begin
			n_errors++;
			$display("FAIL %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// a used-up wait bound is a mismatch and ends the run
	task bound(input int k, input int lim);
		if (k >= lim) begin
			n_errors++;
			stop_test;
		end
	endtask : bound
	// one access, held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
		if (i >= 50) begin
			n_errors++;
			stop_test;
		end
	endtask : bus
	// gate rising edges over n cycles
	task pulses(input int n, output int c);
		logic p;
		c = 0;
		p = gate;
		repeat (n) begin
			@(posedge sys_clk);
			if (gate === 1'b1 && p !== 1'b1) c++;
			p = gate;
		end
	endtask : pulses
	// expected setpoint from analog code, duty and curve option
	function automatic int model_sp(int a, int h, int p, bit cur);
		int s, d;
		s = (a - 256) * 2;
		if (s > 1023) s = 1023;
		d = h * 1024 / p;
		if (d > 952) d = 1024;
		s = s * d / 1024;
		if (s > 1023) s = 1023;
		if (cur) s = s * s / 1024;
		return s;
	endfunction : model_sp
	// --------
	// main sequence
	// --------
	initial begin
		int c, k, e;
		static int ta[$] = {'h300, 'h200, 'h180, 'h140};
		static int vl[$] = {0, 0, 0, 0, 1, 1};
		static int va[$] = {'h300, 'h266, 'h2b3, 'h300, 'h300, 'h300};
		static int vc[$] = {'h20, 'h20, 'h20, 'h20, 'h20, 'h28};
		static int vv[$] = {1, 2, 2, 1, 2, 3};
		static int cl[$] = {0, 10, 51, 82};
		static int pc[$] = {'h20, 'h20, 'h20, 'h20, 'h20, 'h24, 'h20};
		static int pa[$] = {'h300, 'h300, 'h300, 'h300, 'h200, 'h300, 'h300};
		// high times in cycles of a 250 cycle period
		static int ph[$] = {125, 230, 235, 0, 125, 125, 25};
		k = $urandom(32'h0000_19eb);
		ph[3] = $urandom_range(225, 105);
		cyc(16);
		rst_n <= 1'b1;
		cyc(2);
		check(sp, 32'h0000_03ff, 0);
		bus(0, 4'h0, 32'h0000_0000);
		check(rd, 32'h0000_0020, 0);
		bus(1, 4'hc, 32'h0000_0000);
		bus(0, 4'hc, 32'h0000_0000);
		check(rd, 32'h0000_0000, 0);
		foreach (ta[i]) begin
			analog <= 10'(ta[i]);
			cyc(200);
			c = model_sp(ta[i], 1, 1, 0);
			check(sp, c, 8);
			bus(0, 4'h4, 32'h0000_0000);
			check(rd[13], c < 153, 0);
		end
		foreach (vl[i]) begin
			line <= vl[i][0];
			analog <= 10'(va[i]);
			bus(1, 4'h0, vc[i]);
			cyc(300);
			bus(0, 4'h4, 32'h0000_0000);
			check(rd[17:15], vv[i], 0);
		end
		line <= 1'b0;
		for (k = 0; k < 4; k++) begin
			bus(1, 4'h0, 32'h0000_0030 | k);
			analog <= 10'h0a0;
			cyc(200);
			check(sp, cl[k], 2);
			check(flag, 1, 0);
		end
		analog <= 10'h300;
		cyc(200);
		check(flag, 0, 0);
		bus(1, 4'h0, 32'h0000_0020);
		analog <= 10'h080;
		cyc(20);
		pulses(300, c);
		check(c, 0, 0);
		analog <= 10'h300;
		cyc(2);
		// enable while dimmed: first valley forced
		bus(0, 4'h4, 32'h0000_0000);
		check(rd[14], 1, 0);
		check(rd[17:15], 1, 0);
		pulses(300, c);
		check(c > 0, 1, 0);
		// zcd_high sense went high in off time: force released
		bus(0, 4'h4, 32'h0000_0000);
		check(rd[14], 0, 0);
		open <= 1'b0;
		foreach (ph[i]) begin
			bus(1, 4'h0, pc[i]);
			analog <= 10'(pa[i]);
			hi <= 16'(ph[i]);
			cyc(8000);
			c = model_sp(pa[i], ph[i], 250, pc[i][2]);
			check(sp, c, 16);
			check(flag, ph[i] < 400, 0);
		end
		hi <= 16'h03e8;
		cyc(5000);
		check(sp, 32'h0000_03ff, 16);
		hi <= 16'h0000;
		cyc(3200);
		bus(0, 4'h4, 32'h0000_0000);
		check(rd[11], 1, 0);
		pulses(300, c);
		check(c, 0, 0);
		open <= 1'b1;
		cyc(2000);
		k = 0;
		while (gate !== 1'b0 && k < 100) begin
			@(posedge sys_clk);
			k++;
		end
		bound(k, 100);
		stop <= 1'b1;
		c = 0;
		k = 0;
		while (fault_out !== 1'b1 && k < 20000) begin
			pulses(1, e);
			c += e;
			k++;
		end
		bound(k, 20000);
		check(c, 4, 0);
		stop <= 1'b0;
		k = 0;
		while (fault_out !== 1'b0 && k < 2000) begin
			@(posedge sys_clk);
			k++;
		end
		bound(k, 2000);
		check(fault_out, 0, 0);
		stop_test;
	end
endmodule : led_dimming_valley_control_tb_top
